// ===== rtl/pllsup_map.vh
/*
 clock supervision constants: strap decode, power modes, reset drive length.
 assumes an includer that runs on a single clock with one-cycle enables.
*/
`ifndef PLLSUP_MAP_VH
`define PLLSUP_MAP_VH
`define PLLSUP_MODE_RUN 2'h0
`define PLLSUP_MODE_IDLE 2'h1
`define PLLSUP_MODE_PDOWN 2'h2
`define PLLSUP_MODE_STBY 2'h3
`define PLLSUP_SRC_PLL 2'h0
`define PLLSUP_SRC_DIRECT 2'h1
`define PLLSUP_SRC_PRESC 2'h2
`define PLLSUP_STRAP_DIRECT 3'h3
`define PLLSUP_STRAP_PRESC 3'h1
`define PLLSUP_RST_HALF_PERIODS 11'h400
`define PLLSUP_DIV_PLL 4'h0
`define PLLSUP_DIV_DIRECT 4'h0
`define PLLSUP_DIV_PRESC 4'h1
`define PLLSUP_DIV_BACKUP 4'h7
`endif

// ===== rtl/pllsup_top.v
/*
 clock supervision: strap source select, half-period edge enables, pll unlock
 handling, bidirectional reset pin drive, power mode gating.
 assumes all inputs synchronous to sys_clk_i; reset pin is open drain outside.
*/
`timescale 1ns/100ps
`include "pllsup_map.vh"
module pllsup_top #(
	parameter HP_W = 11
) (
	input wire sys_clk_i,
	input wire arst_n_i,
	input wire [2:0] clock_select_straps_i,
	input wire pll_locked_i,
	input wire [1:0] power_mode_i,
	input wire bidir_reset_en_i,
	input wire soft_reset_i,
	input wire wdog_reset_i,
	input wire power_down_pin_i,
	input wire reset_input_pin_i,
	output reg reset_input_pin_o,
	output reg reset_input_pin_oe_n_o,
	output reg [1:0] clk_source_o,
	output reg pll_ref_connected_o,
	output reg backup_clk_sel_o,
	output reg unlock_irq_o,
	output reg half_period_en_o,
	output reg rise_en_o,
	output reg fall_en_o,
	output reg cpu_clk_en_o,
	output reg periph_clk_en_o,
	output reg main_osc_en_o,
	output reg vdd_domain_on_o,
	output reg ext_ram_power_o,
	output reg standby_ram_bias_o
);
	localparam ST_NORMAL = 2'h0;
	localparam ST_DRIVE = 2'h1;
	localparam ST_WAITHI = 2'h2;
	reg rst_s1_r;
	reg rst_s2_r;
	reg strap_done_r;
	reg [3:0] div_r;
	reg [3:0] div_nxt;
	reg phase_r;
	reg [1:0] st_r;
	reg [HP_W-1:0] hp_cnt_r;
	reg lock_d_r;
	wire rst_n;
	wire hp_tick;
	wire sw_req;
	wire [1:0] src_sel;

	assign rst_n = rst_s2_r;

	function [1:0] strap_decode;
		input [2:0] s;
		begin
			if (s == `PLLSUP_STRAP_DIRECT) begin
				strap_decode = `PLLSUP_SRC_DIRECT;
			end else if (s == `PLLSUP_STRAP_PRESC) begin
				strap_decode = `PLLSUP_SRC_PRESC;
			end else begin
				strap_decode = `PLLSUP_SRC_PLL;
			end
		end
	endfunction

	// modes in which peripherals and the main oscillator keep running
	function mode_clocked;
		input [1:0] m;
		begin
			mode_clocked = (m == `PLLSUP_MODE_RUN) || (m == `PLLSUP_MODE_IDLE);
		end
	endfunction

	// modes in which the main supply domain stays on
	function mode_supplied;
		input [1:0] m;
		begin
			mode_supplied = (m != `PLLSUP_MODE_STBY);
		end
	endfunction

	always @(posedge sys_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	// latch the source once, first cycle after release
	always @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			strap_done_r <= 1'b0;
			clk_source_o <= `PLLSUP_SRC_PLL;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			clk_source_o <= strap_decode(clock_select_straps_i);
		end
	end

	// strap levels rule until latched, so spacing is right from the first tick
	assign src_sel = strap_done_r ? clk_source_o : strap_decode(clock_select_straps_i);

	// half-period spacing depends on source and on backup running
	always @* begin
		div_nxt = `PLLSUP_DIV_PLL;
		if (backup_clk_sel_o) begin
			div_nxt = `PLLSUP_DIV_BACKUP;
		end else if (src_sel == `PLLSUP_SRC_DIRECT) begin
			div_nxt = `PLLSUP_DIV_DIRECT;
		end else if (src_sel == `PLLSUP_SRC_PRESC) begin
			div_nxt = `PLLSUP_DIV_PRESC;
		end
	end
	assign hp_tick = (div_r == 4'h0);

	always @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= 4'h0;
			phase_r <= 1'b0;
			half_period_en_o <= 1'b0;
			rise_en_o <= 1'b0;
			fall_en_o <= 1'b0;
		end else begin
			div_r <= hp_tick ? div_nxt : div_r - 4'h1;
			half_period_en_o <= hp_tick;
			if (hp_tick) begin
				phase_r <= ~phase_r;
			end
			rise_en_o <= hp_tick & ~phase_r;
			fall_en_o <= hp_tick & phase_r;
		end
	end

	assign sw_req = (soft_reset_i | wdog_reset_i) & bidir_reset_en_i & power_down_pin_i;

	always @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_NORMAL;
			hp_cnt_r <= {HP_W{1'b0}};
			lock_d_r <= 1'b0;
			unlock_irq_o <= 1'b0;
			pll_ref_connected_o <= 1'b1;
			backup_clk_sel_o <= 1'b0;
			reset_input_pin_o <= 1'b1;
			reset_input_pin_oe_n_o <= 1'b1;
		end else begin
			lock_d_r <= pll_locked_i;
			unlock_irq_o <= 1'b0;
			if (st_r == ST_NORMAL && clk_source_o == `PLLSUP_SRC_PLL && strap_done_r &&
				pll_ref_connected_o && lock_d_r && !pll_locked_i) begin
				unlock_irq_o <= 1'b1;
				pll_ref_connected_o <= 1'b0;
				backup_clk_sel_o <= 1'b1;
			end
			case (st_r)
			ST_NORMAL: begin
				if (sw_req) begin
					st_r <= ST_DRIVE;
					hp_cnt_r <= {HP_W{1'b0}};
					reset_input_pin_o <= 1'b0;
					reset_input_pin_oe_n_o <= 1'b0;
				end
			end
			ST_DRIVE: begin
				// counts internal ticks; the pin is released on the last one
				if (hp_tick) begin
					if (hp_cnt_r == `PLLSUP_RST_HALF_PERIODS - 11'h1) begin
						st_r <= ST_WAITHI;
						reset_input_pin_o <= 1'b1;
						reset_input_pin_oe_n_o <= 1'b1;
					end else begin
						hp_cnt_r <= hp_cnt_r + {{(HP_W-1){1'b0}}, 1'b1};
					end
				end
			end
			ST_WAITHI: begin
				// outside circuit keeps pin low a while; the reference reconnects once the pin reads high
				if (reset_input_pin_i) begin
					st_r <= ST_NORMAL;
					pll_ref_connected_o <= 1'b1;
					backup_clk_sel_o <= 1'b0;
				end
			end
			default: begin
				st_r <= ST_NORMAL;
			end
			endcase
		end
	end

	always @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cpu_clk_en_o <= 1'b0;
			periph_clk_en_o <= 1'b0;
			main_osc_en_o <= 1'b1;
			vdd_domain_on_o <= 1'b1;
			ext_ram_power_o <= 1'b1;
			standby_ram_bias_o <= 1'b1;
		end else begin
			// only run mode clocks the cpu
			cpu_clk_en_o <= (power_mode_i == `PLLSUP_MODE_RUN);

			periph_clk_en_o <= mode_clocked(power_mode_i);
			main_osc_en_o <= mode_clocked(power_mode_i);

			vdd_domain_on_o <= mode_supplied(power_mode_i);
			ext_ram_power_o <= mode_supplied(power_mode_i);

			// standby ram stays biased in every mode
			standby_ram_bias_o <= 1'b1;
		end
	end
endmodule

// ===== test/pllsup_partner.sv
/* reset pin with rc stretch and pll lock model.
 assumes the design clock and an open-drain pin. */
`timescale 1ns/100ps
module pllsup_partner #(parameter STRETCH = 40) (
	input wire logic clk_i, fail_i, ref_on_i, oe_n_i,
	output logic pin_o, locked_o
);
	logic [7:0] cnt_r = 8'h0;
	initial begin
		pin_o = 1'b1;
		locked_o = 1'b1;
	end
	always @(posedge clk_i) begin
		cnt_r <= oe_n_i ? cnt_r - {7'h0, cnt_r != 8'h0} : 8'(STRETCH);
		pin_o <= oe_n_i && cnt_r == 8'h0;
		locked_o <= ref_on_i && !fail_i;
	end
endmodule

// ===== test/pllsup_properties.sv
/* checker on the pllsup_top ports.
 assumes one clock and the bind at the foot. */
`timescale 1ns/100ps
module pllsup_chk (
	input logic sys_clk_i, arst_n_i, pll_locked_i, bidir_reset_en_i, power_down_pin_i,
	input logic reset_input_pin_i, reset_input_pin_oe_n_o, pll_ref_connected_o,
	input logic backup_clk_sel_o, unlock_irq_o, half_period_en_o, rise_en_o, fall_en_o,
	input logic cpu_clk_en_o, periph_clk_en_o, ext_ram_power_o, standby_ram_bias_o,
	input logic [1:0] power_mode_i, clk_source_o
);
	logic [12:0] hp_r = 13'h0;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	// half-periods seen while the pin is driven
	always @(posedge sys_clk_i)
		hp_r <= reset_input_pin_oe_n_o ? 13'h0 : hp_r + {12'h0, half_period_en_o};
	AST_IRQ_ONE: assert property (unlock_irq_o |=> !unlock_irq_o)
		else $error("irq longer than one cycle");
	AST_UNLOCK: assert property ($fell(pll_locked_i) && clk_source_o == 2'h0 &&
		pll_ref_connected_o && reset_input_pin_oe_n_o |-> ##[1:2] unlock_irq_o && !pll_ref_connected_o)
		else $error("unlock not handled");
	AST_BACKUP: assert property (backup_clk_sel_o == !pll_ref_connected_o)
		else $error("backup select wrong");
	AST_RECONNECT: assert property ($rose(pll_ref_connected_o) |-> $past(reset_input_pin_i))
		else $error("reference back without pin high");
	AST_GATE: assert property ($fell(reset_input_pin_oe_n_o) |->
		$past(bidir_reset_en_i) && $past(power_down_pin_i)) else $error("pin driven wrongly");
	AST_LEN: assert property ($rose(reset_input_pin_oe_n_o) |-> hp_r inside {[1023:1024]})
		else $error("drive length wrong");
	AST_EDGES: assert property (half_period_en_o |-> rise_en_o ^ fall_en_o)
		else $error("edge enable wrong");
	AST_PRESC: assert property (clk_source_o == 2'h2 && pll_ref_connected_o &&
		half_period_en_o |=> !half_period_en_o ##1 half_period_en_o) else $error("bad spacing");
	AST_IDLE: assert property ($past(power_mode_i) == 2'h1 |-> !cpu_clk_en_o && periph_clk_en_o)
		else $error("idle gating wrong");
	AST_STBY: assert property ($past(power_mode_i) == 2'h3 |-> !ext_ram_power_o &&
		standby_ram_bias_o && !periph_clk_en_o) else $error("standby gating wrong");
endmodule
bind pllsup_top pllsup_chk u_chk (.*);

// ===== test/pllsup_top_tb.sv
/* self-checking bench for pllsup_top.
 assumes the partner model and the bound checker. */
`timescale 1ns/100ps
module pllsup_top_tb;
	logic sys_clk_i = 1'b0, arst_n_i = 1'b0, bidir_reset_en_i = 1'b1, soft_reset_i = 1'b0;
	logic wdog_reset_i = 1'b0, power_down_pin_i = 1'b1, fail = 1'b0, ref_q = 1'b1;
	logic [2:0] clock_select_straps_i = 3'h0;
	logic [1:0] power_mode_i = 2'h0, clk_source_o, q[$], m;
	logic pll_locked_i, reset_input_pin_i, reset_input_pin_o, reset_input_pin_oe_n_o;
	logic pll_ref_connected_o, backup_clk_sel_o, unlock_irq_o, half_period_en_o, rise_en_o;
	logic fall_en_o, cpu_clk_en_o, periph_clk_en_o, main_osc_en_o, vdd_domain_on_o;
	logic ext_ram_power_o, standby_ram_bias_o;
	int err_total = 0, compares = 0;
	always #20 sys_clk_i = ~sys_clk_i;
	pllsup_partner u_far (.clk_i(sys_clk_i), .fail_i(fail), .ref_on_i(pll_ref_connected_o),
		.oe_n_i(reset_input_pin_oe_n_o), .pin_o(reset_input_pin_i), .locked_o(pll_locked_i));
	pllsup_top dut (.*);
	task cmp(input string n, input logic [1:0] e, input logic [1:0] s);
		compares++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task end_of_test;
		if (err_total == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask
	task rst(input logic [2:0] s);
		arst_n_i <= 1'b0;
		clock_select_straps_i <= s;
		cyc(8);
		arst_n_i <= 1'b1;
		cyc(4);
	endtask
	task pulse(input logic w);
		if (w) wdog_reset_i <= 1'b1; else soft_reset_i <= 1'b1;
		cyc(1);
		{wdog_reset_i, soft_reset_i} <= 2'h0;
		cyc(30);
	endtask
	task wait_ref(input logic v);
		for (int i = 0; i < 20000 && pll_ref_connected_o !== v; i++) cyc(1);
	endtask
	// each change of the reference path takes the oldest note
	always @(posedge sys_clk_i) begin
		ref_q <= pll_ref_connected_o;
		if (arst_n_i && pll_ref_connected_o !== ref_q)
			cmp("irq_bsel", q.size() ? q.pop_front() : 2'bxx, {unlock_irq_o, backup_clk_sel_o});
	end
	initial begin
		void'($urandom(32'h0b86c3aa));
		for (int s = 0; s < 8; s++) begin
			rst(3'(s));
			cmp("src", s == 3 ? 2'h1 : s == 1 ? 2'h2 : 2'h0, clk_source_o);
			cyc(8);
		end
		repeat (40) begin
			m = 2'($urandom);
			power_mode_i <= m;
			cyc(3);
			cmp("cpu_per", {m == 2'h0, m <= 2'h1}, {cpu_clk_en_o, periph_clk_en_o});
			cmp("osc_vdd", {m <= 2'h1, m != 2'h3}, {main_osc_en_o, vdd_domain_on_o});
			cmp("ram", {m != 2'h3, 1'b1}, {ext_ram_power_o, standby_ram_bias_o});
		end
		power_mode_i <= 2'h0;
		rst(3'h0);
		power_down_pin_i <= 1'b0;
		pulse(1'b0);
		cmp("oe_n", 2'h1, {1'b0, reset_input_pin_oe_n_o});
		power_down_pin_i <= 1'b1;
		pulse(1'b0);
		cmp("pin_drv", 2'h0, {reset_input_pin_o, reset_input_pin_oe_n_o});
		cyc(1150);
		fail <= 1'b1;
		q.push_back(2'h3);
		wait_ref(1'b0);
		fail <= 1'b0;
		power_down_pin_i <= 1'b0;
		pulse(1'b1);
		cmp("ref", 2'h0, {1'b0, pll_ref_connected_o});
		power_down_pin_i <= 1'b1;
		q.push_back(2'h0);
		pulse(1'b1);
		wait_ref(1'b1);
		cyc(20);
		end_of_test;
	end
	initial begin
		#(40 * 40000);
		err_total++;
		end_of_test;
	end
endmodule
